// ### design/cdm_pkg.sv
// Shared constants and types for the data-move decode block
package cdm_pkg;

    // ************************************************************
    // Operand sizes and address constants
    // ************************************************************
    localparam logic [1:0]  SZ_BYTE      = 2'h0;
    localparam logic [1:0]  SZ_WORD      = 2'h1;
    localparam logic [1:0]  SZ_LONG      = 2'h2;
    localparam logic [1:0]  SZ_BAD       = 2'h3;
    localparam logic [31:0] PC_AHEAD     = 32'h0000_0004;
    localparam logic [31:0] PC_LONG_MASK = 32'hFFFF_FFFC;
    localparam logic [3:0]  REG_ZERO     = 4'h0;
    localparam int          NUM_REGS     = 16;
    localparam int          DATA_W       = 32;

    // ************************************************************
    // Opcode fields
    // ************************************************************
    localparam logic [3:0]  OPC_IMM      = 4'hE;
    localparam logic [3:0]  OPC_PCW      = 4'h9;
    localparam logic [3:0]  OPC_PCL      = 4'hD;
    localparam logic [3:0]  OPC_IND_ST   = 4'h2;
    localparam logic [3:0]  OPC_IND_LD   = 4'h6;
    localparam logic [3:0]  OPC_IDX      = 4'h0;
    localparam logic [3:0]  OPC_DISP_STL = 4'h1;
    localparam logic [3:0]  OPC_DISP_LDL = 4'h5;
    localparam logic [3:0]  OPC_DISP_BW  = 4'h8;
    localparam logic [1:0]  SUB_PLAIN    = 2'h0;
    localparam logic [1:0]  SUB_AUTO     = 2'h1;
    localparam logic [2:0]  DBW_STORE    = 3'h0;
    localparam logic [2:0]  DBW_LOAD     = 3'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        OP_NONE    = 4'b0000,
        OP_IMM     = 4'b0001,
        OP_LD_PC   = 4'b0010,
        OP_ST_IND  = 4'b0011,
        OP_LD_IND  = 4'b0100,
        OP_ST_PRE  = 4'b0101,
        OP_LD_POST = 4'b0110,
        OP_ST_DBW  = 4'b0111,
        OP_ST_DL   = 4'b1000,
        OP_LD_DISP = 4'b1001,
        OP_ST_IDX  = 4'b1010
    } cdm_op_t;

    typedef struct packed {
        logic        ld_v;
        logic [3:0]  ld_dest;
        logic [31:0] ld_data;
        logic        t_flag;
    } cdm_state_t;

endpackage

// ### design/cdm_rf_if.sv
// Register file access bundle between core and register file
`timescale 1ns/1ps
interface cdm_rf_if;
    logic [3:0]  rd_n_idx;
    logic [3:0]  rd_m_idx;
    logic [31:0] rd_n;
    logic [31:0] rd_m;
    logic [31:0] rd_zero;
    logic        wr1_en;
    logic [3:0]  wr1_idx;
    logic [31:0] wr1_data;
    logic        wr2_en;
    logic [3:0]  wr2_idx;
    logic [31:0] wr2_data;

    modport core (
        output rd_n_idx, rd_m_idx, wr1_en, wr1_idx, wr1_data,
        output wr2_en, wr2_idx, wr2_data,
        input  rd_n, rd_m, rd_zero
    );
    modport rf (
        input  rd_n_idx, rd_m_idx, wr1_en, wr1_idx, wr1_data,
        input  wr2_en, wr2_idx, wr2_data,
        output rd_n, rd_m, rd_zero
    );
endinterface

// ### design/cdm_regfile.sv
// Sixteen general registers, two read ports plus register zero
`timescale 1ns/1ps
module cdm_regfile (
    input  wire logic i_clk,
    input  wire logic i_rst,
    cdm_rf_if.rf      rf
);
    logic [31:0] regs [cdm_pkg::NUM_REGS];

    // ************************************************************
    // Direct binary indexing
    // ************************************************************
    assign rf.rd_n    = regs[rf.rd_n_idx];
    assign rf.rd_m    = regs[rf.rd_m_idx];
    assign rf.rd_zero = regs[cdm_pkg::REG_ZERO];

    // Port 1 is the later instruction, so it wins a clash
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < cdm_pkg::NUM_REGS; i++) begin
                regs[i] <= 32'h0000_0000;
            end
        end else begin
            if (rf.wr2_en) begin
                regs[rf.wr2_idx] <= rf.wr2_data;
            end
            if (rf.wr1_en) begin
                regs[rf.wr1_idx] <= rf.wr1_data;
            end
        end
    end
endmodule

// ### design/cdm_agu.sv
// Address generator with size scaling and pre-decrement
`timescale 1ns/1ps
module cdm_agu (
    input  wire logic [31:0] i_base,
    input  wire logic [31:0] i_index,
    input  wire logic        i_use_index,
    input  wire logic        i_dec,
    input  wire logic [7:0]  i_disp,
    input  wire logic [1:0]  i_size,
    output logic      [31:0] o_addr,
    output logic      [31:0] o_step
);
    logic [31:0] scaled;

    always_comb begin
        case (i_size)
            cdm_pkg::SZ_WORD: begin
                scaled = {23'h0, i_disp, 1'b0};
                o_step = 32'h0000_0002;
            end
            cdm_pkg::SZ_LONG: begin
                scaled = {22'h0, i_disp, 2'h0};
                o_step = 32'h0000_0004;
            end
            default: begin
                scaled = {24'h0, i_disp};
                o_step = 32'h0000_0001;
            end
        endcase
        if (i_dec) begin
            o_addr = i_base - o_step;
        end else if (i_use_index) begin
            o_addr = i_base + i_index;
        end else begin
            o_addr = i_base + scaled;
        end
    end
endmodule

// ### design/cdm_core.sv
// Data-move instruction decode and execute unit
// Function
// - Register fields index sixteen registers directly
// - Each transfer takes one cycle without waits
// - Fetch contention on memory path adds cycles
// - Stall reader of register a load writes
// - Displacement scaled by one, two, four
// - Immediate sign-extended into destination register
// - Word load at pc plus twice displacement
// - Longword load at pc plus four displacement
// - Register-indirect store and sign-extending load
// - Pre-decrement destination, then store source
// - Load, then post-increment source by size unless it is the destination
// - Byte/word store of register zero, displacement
// - Longword store any register with displacement
// - Byte/word displacement load into register zero
// - Longword displacement load into any register
// - Indexed store at register zero plus destination
// - Transfers never change the test flag
`timescale 1ns/1ps
module cdm_core (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_instr_valid,
    input  wire logic [15:0] i_instr,
    input  wire logic [31:0] i_instr_pc,
    output logic             o_instr_ready,
    input  wire logic        i_fetch_busy,
    output logic             o_mem_req,
    output logic             o_mem_we,
    output logic      [1:0]  o_mem_size,
    output logic      [31:0] o_mem_addr,
    output logic      [31:0] o_mem_wdata,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_rdata,
    input  wire logic        i_t_wr,
    input  wire logic        i_t_data,
    output logic             o_t_flag
);
    cdm_pkg::cdm_state_t st_reg;
    cdm_pkg::cdm_state_t st_next;
    cdm_pkg::cdm_op_t    op;
    cdm_rf_if            rf ();

    logic [3:0]  fld_n;
    logic [3:0]  fld_m;
    logic [3:0]  fld_lo;
    logic [1:0]  size;
    logic        uses_n;
    logic        uses_m;
    logic        uses_r0;
    logic        is_load;
    logic        is_store;
    logic        hazard;
    logic        done;
    logic [3:0]  ld_dest;
    logic [31:0] pc_base;
    logic [31:0] agu_base;
    logic [31:0] agu_index;
    logic        agu_use_index;
    logic        agu_dec;
    logic [7:0]  agu_disp;
    logic [31:0] agu_addr;
    logic [31:0] agu_step;

    function automatic logic [31:0] sext(input logic [31:0] d,
                                         input logic [1:0]  sz);
        case (sz)
            cdm_pkg::SZ_BYTE: sext = {{24{d[7]}}, d[7:0]};
            cdm_pkg::SZ_WORD: sext = {{16{d[15]}}, d[15:0]};
            default:          sext = d;
        endcase
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    assign fld_n  = i_instr[11:8];
    assign fld_m  = i_instr[7:4];
    assign fld_lo = i_instr[3:0];

    always_comb begin
        op      = cdm_pkg::OP_NONE;
        size    = cdm_pkg::SZ_LONG;
        uses_n  = 1'b0;
        uses_m  = 1'b0;
        uses_r0 = 1'b0;
        case (i_instr[15:12])
            cdm_pkg::OPC_IMM: op = cdm_pkg::OP_IMM;
            cdm_pkg::OPC_PCW: begin
                op   = cdm_pkg::OP_LD_PC;
                size = cdm_pkg::SZ_WORD;
            end
            cdm_pkg::OPC_PCL: op = cdm_pkg::OP_LD_PC;
            cdm_pkg::OPC_IND_ST: begin
                if (fld_lo[3] == 1'b0 && fld_lo[1:0] != cdm_pkg::SZ_BAD) begin
                    op = (fld_lo[3:2] == cdm_pkg::SUB_AUTO) ?
                         cdm_pkg::OP_ST_PRE : cdm_pkg::OP_ST_IND;
                    size   = fld_lo[1:0];
                    uses_n = 1'b1;
                    uses_m = 1'b1;
                end
            end
            cdm_pkg::OPC_IND_LD: begin
                if (fld_lo[3] == 1'b0 && fld_lo[1:0] != cdm_pkg::SZ_BAD) begin
                    op = (fld_lo[3:2] == cdm_pkg::SUB_AUTO) ?
                         cdm_pkg::OP_LD_POST : cdm_pkg::OP_LD_IND;
                    size   = fld_lo[1:0];
                    uses_m = 1'b1;
                end
            end
            cdm_pkg::OPC_IDX: begin
                if (fld_lo[3:2] == cdm_pkg::SUB_AUTO &&
                    fld_lo[1:0] != cdm_pkg::SZ_BAD) begin
                    op      = cdm_pkg::OP_ST_IDX;
                    size    = fld_lo[1:0];
                    uses_n  = 1'b1;
                    uses_m  = 1'b1;
                    uses_r0 = 1'b1;
                end
            end
            cdm_pkg::OPC_DISP_STL: begin
                op     = cdm_pkg::OP_ST_DL;
                uses_n = 1'b1;
                uses_m = 1'b1;
            end
            cdm_pkg::OPC_DISP_LDL: begin
                op     = cdm_pkg::OP_LD_DISP;
                uses_m = 1'b1;
            end
            cdm_pkg::OPC_DISP_BW: begin
                size = {1'b0, i_instr[8]};
                if (i_instr[11:9] == cdm_pkg::DBW_STORE) begin
                    op      = cdm_pkg::OP_ST_DBW;
                    uses_m  = 1'b1;
                    uses_r0 = 1'b1;
                end else if (i_instr[11:9] == cdm_pkg::DBW_LOAD) begin
                    op     = cdm_pkg::OP_LD_DISP;
                    uses_m = 1'b1;
                end
            end
            default: op = cdm_pkg::OP_NONE;
        endcase
    end

    // ************************************************************
    // Address and data path
    // ************************************************************
    assign pc_base = (size == cdm_pkg::SZ_LONG) ?
        ((i_instr_pc + cdm_pkg::PC_AHEAD) & cdm_pkg::PC_LONG_MASK) :
        (i_instr_pc + cdm_pkg::PC_AHEAD);

    always_comb begin
        agu_base      = rf.rd_m;
        agu_index     = rf.rd_n;
        agu_use_index = 1'b0;
        agu_dec       = 1'b0;
        agu_disp      = {4'h0, fld_lo};
        is_load       = 1'b0;
        is_store      = 1'b0;
        ld_dest       = fld_n;
        o_mem_wdata   = rf.rd_m;
        case (op)
            cdm_pkg::OP_LD_PC: begin
                agu_base = pc_base;
                agu_disp = i_instr[7:0];
                is_load  = 1'b1;
            end
            cdm_pkg::OP_ST_IND: begin
                agu_base = rf.rd_n;
                agu_disp = 8'h00;
                is_store = 1'b1;
            end
            cdm_pkg::OP_ST_PRE: begin
                agu_base = rf.rd_n;
                agu_dec  = 1'b1;
                is_store = 1'b1;
            end
            cdm_pkg::OP_LD_IND, cdm_pkg::OP_LD_POST: begin
                agu_disp = 8'h00;
                is_load  = 1'b1;
            end
            cdm_pkg::OP_ST_DBW: begin
                o_mem_wdata = rf.rd_zero;
                is_store    = 1'b1;
            end
            cdm_pkg::OP_ST_DL: begin
                agu_base = rf.rd_n;
                is_store = 1'b1;
            end
            cdm_pkg::OP_LD_DISP: begin
                if (size != cdm_pkg::SZ_LONG) begin
                    ld_dest = cdm_pkg::REG_ZERO;
                end
                is_load = 1'b1;
            end
            cdm_pkg::OP_ST_IDX: begin
                agu_base      = rf.rd_zero;
                agu_use_index = 1'b1;
                is_store      = 1'b1;
            end
            default: is_load = 1'b0;
        endcase
    end

    cdm_agu u_agu (
        .i_base      (agu_base),
        .i_index     (agu_index),
        .i_use_index (agu_use_index),
        .i_dec       (agu_dec),
        .i_disp      (agu_disp),
        .i_size      (size),
        .o_addr      (agu_addr),
        .o_step      (agu_step)
    );

    // ************************************************************
    // Handshake and stalls
    // ************************************************************
    assign hazard = st_reg.ld_v &&
                    ((uses_n  && st_reg.ld_dest == fld_n) ||
                     (uses_m  && st_reg.ld_dest == fld_m) ||
                     (uses_r0 && st_reg.ld_dest == cdm_pkg::REG_ZERO));

    assign o_mem_req  = i_instr_valid && (is_load || is_store) &&
                        !hazard && !i_fetch_busy;
    assign o_mem_we   = is_store;
    assign o_mem_size = size;
    assign o_mem_addr = agu_addr;
    assign done       = i_instr_valid && !hazard &&
                        (!(is_load || is_store) || (o_mem_req && i_mem_ack));
    assign o_instr_ready = done;
    assign o_t_flag      = st_reg.t_flag;

    // ************************************************************
    // Register writes and state
    // ************************************************************
    assign rf.rd_n_idx = fld_n;
    assign rf.rd_m_idx = fld_m;
    assign rf.wr2_en   = st_reg.ld_v;
    assign rf.wr2_idx  = st_reg.ld_dest;
    assign rf.wr2_data = st_reg.ld_data;

    always_comb begin
        rf.wr1_en   = 1'b0;
        rf.wr1_idx  = fld_n;
        rf.wr1_data = {{24{i_instr[7]}}, i_instr[7:0]};
        if (done) begin
            if (op == cdm_pkg::OP_IMM) begin
                rf.wr1_en = 1'b1;
            end else if (op == cdm_pkg::OP_ST_PRE) begin
                rf.wr1_en   = 1'b1;
                rf.wr1_data = agu_addr;
            end else if (op == cdm_pkg::OP_LD_POST && fld_n != fld_m) begin
                rf.wr1_en   = 1'b1;
                rf.wr1_idx  = fld_m;
                rf.wr1_data = rf.rd_m + agu_step;
            end
        end
    end

    always_comb begin
        st_next         = st_reg;
        st_next.ld_v    = done && is_load;
        st_next.ld_dest = ld_dest;
        st_next.ld_data = sext(i_mem_rdata, size);
        if (i_t_wr) begin
            st_next.t_flag = i_t_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    cdm_regfile u_rf (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .rf    (rf.rf)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    a_zero_wait_done:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_mem_req && i_mem_ack |-> o_instr_ready)
        else $error("zero-wait transfer did not finish");

    a_fetch_blocks_mem:
    assert property (@(posedge i_clk) disable iff (i_rst)
        i_fetch_busy |-> !o_mem_req && !(o_instr_ready && o_mem_we))
        else $error("data access during fetch contention");

    a_load_use_stall:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_instr_ready && is_load ##1 i_instr_valid && uses_m &&
        fld_m == $past(ld_dest) |-> !o_instr_ready)
        else $error("reader of pending load not stalled");

    a_imm_write:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_instr_ready && op == cdm_pkg::OP_IMM |->
        rf.wr1_en && rf.wr1_idx == i_instr[11:8] &&
        rf.wr1_data == {{24{i_instr[7]}}, i_instr[7:0]})
        else $error("immediate not written");

    a_pcl_aligned:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_mem_req && op == cdm_pkg::OP_LD_PC && size == cdm_pkg::SZ_LONG
        |-> o_mem_addr[1:0] == 2'h0 &&
            o_mem_addr == pc_base + {22'h0, i_instr[7:0], 2'h0})
        else $error("longword pc-relative address wrong");

    a_predec_addr:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_mem_req && op == cdm_pkg::OP_ST_PRE
        |-> o_mem_addr == rf.rd_n - agu_step &&
            (!i_mem_ack || (rf.wr1_en && rf.wr1_data == o_mem_addr)))
        else $error("pre-decrement address wrong");

    a_load_to_zero:
    assert property (@(posedge i_clk) disable iff (i_rst)
        o_instr_ready && op == cdm_pkg::OP_LD_DISP &&
        size != cdm_pkg::SZ_LONG
        |=> rf.wr2_en && rf.wr2_idx == cdm_pkg::REG_ZERO &&
            rf.wr2_data == sext($past(i_mem_rdata), $past(size)))
        else $error("displacement load missed register zero");

    a_t_flag_kept:
    assert property (@(posedge i_clk) disable iff (i_rst)
        !i_t_wr |=> $stable(o_t_flag))
        else $error("test flag changed by transfer");
endmodule

// ### bench/cdm_mem_model.sv
// Data memory and fetch contention model for the data-move block
`timescale 1ns/1ps
module cdm_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [1:0]  i_wait,
    input  wire logic        i_busy_en,
    output logic             o_busy,
    output logic             o_ack,
    output logic      [31:0] o_rdata
);
    // ****************************************
    // Wait states and fetch contention
    // ****************************************
    logic [1:0]  cnt_reg;
    logic [15:0] cyc_reg;

    function automatic logic [31:0] mval(input logic [31:0] a);
        return {a[15:0] ^ 16'h9C3A, ~a[15:0] ^ 16'h3C81};
    endfunction

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= 2'h0;
            cyc_reg <= 16'h0;
            o_busy  <= 1'b0;
        end else begin
            cyc_reg <= cyc_reg + 16'h1;
            o_busy  <= i_busy_en && (cyc_reg[1:0] == 2'h1 || cyc_reg[4]);
            if (o_ack) begin
                cnt_reg <= 2'h0;
            end else if (i_req) begin
                cnt_reg <= cnt_reg + 2'h1;
            end
        end
    end

    // Idle data lines toggle so stale values never pass
    assign o_ack   = i_req && !o_busy && cnt_reg >= i_wait;
    assign o_rdata = o_ack ? mval(i_addr) : {cyc_reg, ~cyc_reg};
endmodule

// ### bench/tb.sv
// Self-checking bench for the data-move decode block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb;
    // ****************************************
    // Signals and shadow state
    // ****************************************
    logic        i_clk = 1'b0;
    logic        i_rst;
    logic        i_instr_valid;
    logic [15:0] i_instr;
    logic [31:0] i_instr_pc;
    logic        o_instr_ready;
    logic        i_fetch_busy;
    logic        o_mem_req;
    logic        o_mem_we;
    logic [1:0]  o_mem_size;
    logic [31:0] o_mem_addr;
    logic [31:0] o_mem_wdata;
    logic        i_mem_ack;
    logic [31:0] i_mem_rdata;
    logic        i_t_wr = 1'b0;
    logic        i_t_data = 1'b0;
    logic        o_t_flag;
    logic [1:0]  wait_sel;
    logic        busy_en;
    logic        t_exp = 1'b0;
    logic [31:0] rnd = 32'hE0C0;
    logic [31:0] regs [16];
    logic [31:0] pc;
    logic        e_mem;
    logic        e_we;
    logic        e_ld;
    logic [1:0]  e_sz;
    logic [31:0] e_addr;
    logic [31:0] e_wd;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    cdm_core dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_instr_pc(i_instr_pc), .o_instr_ready(o_instr_ready),
        .i_fetch_busy(i_fetch_busy), .o_mem_req(o_mem_req),
        .o_mem_we(o_mem_we), .o_mem_size(o_mem_size),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
        .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
        .i_t_wr(i_t_wr), .i_t_data(i_t_data), .o_t_flag(o_t_flag));

    cdm_mem_model mem (.i_clk(i_clk), .i_rst(i_rst), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_wait(wait_sel), .i_busy_en(busy_en),
        .o_busy(i_fetch_busy), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

    always #25 i_clk = ~i_clk;

    // ****************************************
    // Random source, flag writes and timeout
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    always @(posedge i_clk) begin
        rnd      <= lfsr(rnd);
        i_t_wr   <= rnd[5] & rnd[9];
        i_t_data <= rnd[3];
        t_exp    <= i_rst ? 1'b0 : (i_t_wr ? i_t_data : t_exp);
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            final_report();
        end
    end

    always @(negedge i_clk) begin
        if (!i_rst) begin
            `CHK(o_t_flag, t_exp)
            if (i_fetch_busy) `CHK(o_mem_req, 1'b0)
        end
    end

    // ****************************************
    // Expectation helpers
    // ****************************************
    function automatic logic [31:0] mval(input logic [31:0] a);
        return {a[15:0] ^ 16'h9C3A, ~a[15:0] ^ 16'h3C81};
    endfunction

    function automatic logic [31:0] sext(input logic [31:0] v,
                                         input logic [1:0]  s);
        if (s == 2'h0) return {{24{v[7]}}, v[7:0]};
        if (s == 2'h1) return {{16{v[15]}}, v[15:0]};
        return v;
    endfunction

    function automatic logic [31:0] msk(input logic [1:0] s);
        return (s == 2'h0) ? 32'hFF : (s == 2'h1) ? 32'hFFFF : 32'hFFFF_FFFF;
    endfunction

    task automatic st(input logic [31:0] a, input logic [31:0] v,
                      input logic [1:0] s);
        e_addr = a;
        e_wd   = v;
        e_sz   = s;
        e_we   = 1'b1;
    endtask

    task automatic ld(input logic [3:0] r, input logic [31:0] a,
                      input logic [1:0] s);
        e_addr  = a;
        e_sz    = s;
        e_we    = 1'b0;
        e_ld    = 1'b1;
        regs[r] = sext(mval(a), s);
    endtask

    task automatic predict(input logic [15:0] op);
        logic [3:0]  n;
        logic [3:0]  m;
        logic [1:0]  s;
        logic [31:0] d;
        logic [31:0] p;
        n = op[11:8];
        m = op[7:4];
        s = op[1:0];
        d = {28'h0, op[3:0]};
        p = pc + 32'h4;
        e_mem = 1'b1;
        e_ld = 1'b0;
        case (op[15:12])
            4'hE: begin
                e_mem = 1'b0;
                regs[n] = sext({24'h0, op[7:0]}, 2'h0);
            end
            4'h9: ld(n, p + {23'h0, op[7:0], 1'b0}, 2'h1);
            4'hD: ld(n, (p & 32'hFFFF_FFFC) + {22'h0, op[7:0], 2'h0}, 2'h2);
            4'h2: begin
                if (op[2]) begin
                    st(regs[n] - (32'h1 << s), regs[m], s);
                    regs[n] = e_addr;
                end else begin
                    st(regs[n], regs[m], s);
                end
            end
            4'h6: begin
                ld(n, regs[m], s);
                if (op[2] && n != m)
                    regs[m] = e_addr + (32'h1 << s);
            end
            4'h8: begin
                s = {1'b0, op[8]};
                if (op[10]) ld(4'h0, regs[m] + (d << s), s);
                else st(regs[m] + (d << s), regs[0], s);
            end
            4'h1: st(regs[n] + (d << 2), regs[m], 2'h2);
            4'h5: ld(n, regs[m] + (d << 2), 2'h2);
            4'h0: st(regs[0] + regs[n], regs[m], s);
            default: e_mem = 1'b0;
        endcase
    endtask

    function automatic logic [15:0] gen(input int k, input logic [15:0] r);
        logic [1:0] s;
        s = (r[1:0] == 2'h3) ? 2'h2 : r[1:0];
        case (k)
            0: return {4'hE, r[11:0]};
            1: return {4'h9, r[11:0]};
            2: return {4'hD, r[11:0]};
            3: return {4'h2, r[11:4], 2'h0, s};
            4: return {4'h6, r[11:4], 2'h0, s};
            5: return {4'h2, r[11:4], 2'h1, s};
            6: return {4'h6, r[11:4], 2'h1, s};
            7: return {7'b1000000, r[12], r[7:0]};
            8: return {4'h1, r[11:0]};
            9: return {7'b1000010, r[12], r[7:0]};
            10: return {4'h5, r[11:0]};
            default: return {4'h0, r[11:4], 2'h1, s};
        endcase
    endfunction

    // One instruction; extra is added stall, negative skips the count
    task automatic run(input logic [15:0] op, input logic [1:0] w,
                       input int extra);
        int n;
        n = 0;
        predict(op);
        i_instr_valid <= 1'b1;
        i_instr       <= op;
        i_instr_pc    <= pc;
        wait_sel      <= w;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_instr_ready !== 1'b1 && n < 40);
        `CHK(o_instr_ready, 1'b1)
        `CHK(o_mem_req, e_mem)
        if (e_mem) begin
            `CHK(o_mem_we, e_we)
            `CHK(o_mem_size, e_sz)
            `CHK(o_mem_addr, e_addr)
            if (e_we) `CHK(o_mem_wdata & msk(e_sz), e_wd & msk(e_sz))
        end
        if (extra >= 0) `CHK(n, 1 + (e_mem ? int'(w) : 0) + extra)
        pc = pc + 32'h2;
        @(posedge i_clk);
    endtask

    task automatic final_report();
        $display("Compared %0d, mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        i_rst = 1'b1;
        i_instr_valid = 1'b0;
        i_instr = 16'h0;
        i_instr_pc = 32'h0;
        wait_sel = 2'h0;
        busy_en = 1'b0;
        pc = 32'h0000_1002;
        foreach (regs[i]) regs[i] = 32'h0;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        run(16'hE180, 2'h0, 0);
        run(16'hE27F, 2'h0, 0);
        run(16'hE3F0, 2'h0, 0);
        run(16'h2312, 2'h0, 0);
        run(16'h2311, 2'h2, 0);
        run(16'hD5FF, 2'h0, 0);
        run(16'h94FF, 2'h1, -1);
        run(16'h6532, 2'h0, -1);
        run(16'h2352, 2'h0, 1);
        run(16'h6F36, 2'h0, 0);
        run(16'h2F32, 2'h0, -1);
        run(16'h2F14, 2'h0, 0);
        run(16'h801F, 2'h0, 0);
        run(16'h811F, 2'h0, 0);
        run(16'h1F1F, 2'h0, 0);
        run(16'h841F, 2'h0, 0);
        run(16'h853F, 2'h0, -1);
        run(16'h5A3F, 2'h0, -1);
        run(16'h0F16, 2'h0, -1);
        run(16'h0F14, 2'h1, 0);
        run(16'hF0F0, 2'h0, 0);
        for (int i = 0; i < 400; i++) begin
            busy_en <= (i >= 200);
            run(gen(int'(rnd[7:0]) % 12, rnd[15:0]),
                (rnd[17:16] == 2'h3) ? 2'h0 : rnd[17:16],
                (i >= 200 || e_ld) ? -1 : 0);
        end
        busy_en <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            run({8'h20, 4'(i), 4'h2}, 2'h0, -1);
        end
        i_instr_valid <= 1'b0;
        repeat (2) @(posedge i_clk);
        final_report();
    end
endmodule
